/* File: bbd_decode.sv */
// decode and execute of relative branch, bit set and bit test skip
// assumes instruction word steady for the whole four-phase cycle and
// register read data valid in the q2 phase it is requested
`timescale 1ns/1ns
module bbd_decode (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [15:0] instr_in,
	input wire logic [3:0] bank_select_register_in,
	input wire logic ext_set_en_in,
	input wire logic [bbd_pkg::ADDR_W-1:0] index_base_in,
	input wire logic [7:0] reg_rdata_in,
	output logic [bbd_pkg::PC_W-1:0] pc_out,
	output logic [bbd_pkg::ADDR_W-1:0] reg_addr_out,
	output logic reg_rd_out,
	output logic reg_wr_out,
	output logic [7:0] reg_wdata_out,
	output logic status_wr_out,
	output logic flush_out,
	output logic [1:0] phase_out
);
	bbd_pkg::bbd_phase_e phase;
	logic cycle_end;

	// ==================================================
	// phase sequencer
	bbd_qphase u_qphase (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.phase_out(phase),
		.cycle_end_out(cycle_end)
	);
	assign phase_out = phase;

	// ==================================================
	// opcode decode
	logic is_branch;
	logic is_bit_set;
	logic is_skip_clr;
	logic is_skip_set;
	logic [2:0] bit_sel;
	logic bank_bit;
	logic [7:0] f_addr;

	assign is_branch = (instr_in[15:11] == bbd_pkg::OPC_BRANCH);
	assign is_bit_set = (instr_in[15:12] == bbd_pkg::OPC_BIT_SET);
	assign is_skip_clr = (instr_in[15:12] == bbd_pkg::OPC_SKIP_CLR);
	assign is_skip_set = (instr_in[15:12] == bbd_pkg::OPC_SKIP_SET);
	assign bit_sel = instr_in[11:9];
	assign bank_bit = instr_in[8];
	assign f_addr = instr_in[7:0];

	// data address of a bit-oriented operand
	function automatic logic [bbd_pkg::ADDR_W-1:0] operand_addr(
		input logic a_bit,
		input logic [7:0] f,
		input logic [3:0] bank,
		input logic ext_en,
		input logic [bbd_pkg::ADDR_W-1:0] base
	);
		logic [bbd_pkg::ADDR_W-1:0] addr;
		addr = {bank, f};
		if (!a_bit && ext_en && f <= bbd_pkg::IDX_LIMIT) begin
			addr = base + {4'h0, f};
		end else if (!a_bit) begin
			// access bank: addresses below 0x60 in bank 0, 0x60 and up in top bank
			if (f < bbd_pkg::ACCESS_SPLIT)
				addr = {4'h0, f};
			else
				addr = {bbd_pkg::ACCESS_HI_BANK, f};
		end
		return addr;
	endfunction

	// ==================================================
	// program counter, bubble and skip state
	logic [bbd_pkg::PC_W-1:0] pc_r;
	logic [bbd_pkg::PC_W-1:0] pc_nxt;
	logic flush_r;
	logic flush_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] wdata_r;
	logic [7:0] wdata_nxt;
	logic [bbd_pkg::PC_W-1:0] ofs2;
	logic bit_val;

	// signed offset doubled and widened to counter width
	assign ofs2 = {{(bbd_pkg::PC_W-bbd_pkg::OFS_W-1){instr_in[10]}},
		instr_in[10:0], 1'b0};
	assign bit_val = rdata_r[bit_sel];

	always_comb begin
		pc_nxt = pc_r;
		flush_nxt = flush_r;
		rdata_nxt = rdata_r;
		wdata_nxt = wdata_r;
		if (phase == bbd_pkg::Q2)
			rdata_nxt = reg_rdata_in;
		if (phase == bbd_pkg::Q3)
			wdata_nxt = rdata_r | (8'h01 << bit_sel);
		if (cycle_end) begin
			// pc_r already holds address of this instruction plus two
			flush_nxt = 1'b0;
			pc_nxt = pc_r + bbd_pkg::PC_STEP;
			if (!flush_r) begin
				if (is_branch) begin
					pc_nxt = pc_r + ofs2;
					flush_nxt = 1'b1;
				end else if (is_skip_clr && !bit_val) begin
					flush_nxt = 1'b1;
				end else if (is_skip_set && bit_val) begin
					flush_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pc_r <= bbd_pkg::PC_RESET + bbd_pkg::PC_STEP;
			flush_r <= 1'b0;
			rdata_r <= 8'h00;
			wdata_r <= 8'h00;
		end else begin
			pc_r <= pc_nxt;
			flush_r <= flush_nxt;
			rdata_r <= rdata_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	// ==================================================
	// register port
	logic bitop;
	assign bitop = !flush_r && (is_bit_set || is_skip_clr || is_skip_set);
	assign pc_out = pc_r;
	assign flush_out = flush_r;
	assign reg_addr_out = operand_addr(bank_bit, f_addr,
		bank_select_register_in, ext_set_en_in, index_base_in);
	assign reg_rd_out = bitop && (phase == bbd_pkg::Q2);
	assign reg_wr_out = !flush_r && is_bit_set
		&& (phase == bbd_pkg::Q4);
	assign reg_wdata_out = wdata_r;
	assign status_wr_out = 1'b0;

	// ==================================================
	// assertions
	AST_BRANCH_TARGET: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && !flush_r && is_branch) |=> pc_r == $past(pc_r)
		+ $past(ofs2)) else $error("branch target wrong");
	AST_BRANCH_BUBBLE: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && !flush_r && is_branch) |=> flush_r [*4]
		##1 !flush_r) else $error("branch bubble not one cycle");
	AST_SET_WRITE: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		reg_wr_out |-> reg_wdata_out[bit_sel] == 1'b1)
		else $error("set bit not one");
	AST_SET_KEEP: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		reg_wr_out |-> (reg_wdata_out | (8'h01 << bit_sel))
		== (rdata_r | (8'h01 << bit_sel))) else $error("other bits changed");
	AST_WRITE_PHASE: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		reg_wr_out |-> phase == bbd_pkg::Q4 && $past(reg_rd_out, 2))
		else $error("write not in q4 after q2 read");
	AST_READ_PHASE: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		reg_rd_out |-> phase == bbd_pkg::Q2)
		else $error("read not in q2");
	AST_ACCESS_LOW: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(!bank_bit && !ext_set_en_in && f_addr < bbd_pkg::ACCESS_SPLIT)
		|-> reg_addr_out == {4'h0, f_addr}) else $error("access bank wrong");
	AST_ACCESS_HIGH: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(!bank_bit && f_addr >= bbd_pkg::ACCESS_SPLIT)
		|-> reg_addr_out == {bbd_pkg::ACCESS_HI_BANK, f_addr})
		else $error("access bank high half wrong");
	AST_BANKED: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		bank_bit |-> reg_addr_out == {bank_select_register_in, f_addr})
		else $error("banked address wrong");
	AST_INDEXED: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(!bank_bit && ext_set_en_in && f_addr <= bbd_pkg::IDX_LIMIT)
		|-> reg_addr_out == index_base_in + {4'h0, f_addr})
		else $error("indexed address wrong");
	AST_SKIP_CLR: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && !flush_r && is_skip_clr && !bit_val) |=> flush_r)
		else $error("skip if clear missed");
	AST_SKIP_CLR_HOLD: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && !flush_r && is_skip_clr && bit_val) |=> !flush_r)
		else $error("skip if clear wrongly taken");
	AST_SKIP_SET: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && !flush_r && is_skip_set && !bit_val) |=> !flush_r)
		else $error("skip if set wrongly taken");
	AST_SKIP_SET_TAKEN: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && !flush_r && is_skip_set && bit_val) |=> flush_r)
		else $error("skip if set missed");
	AST_PC_STEP: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		(cycle_end && (flush_r || !is_branch))
		|=> pc_r == $past(pc_r) + bbd_pkg::PC_STEP)
		else $error("counter step wrong");
	AST_PC_HOLD: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		!cycle_end |=> $stable(pc_r))
		else $error("counter moved outside q4");
	AST_FLUSH_IDLE: assert property (@(posedge ref_clk_in)
		disable iff (reset_in)
		flush_r |-> !reg_wr_out && !reg_rd_out)
		else $error("register access in nop cycle");
	// main scenarios seen
	COV_BRANCH: cover property (@(posedge ref_clk_in)
		cycle_end && !flush_r && is_branch);
	COV_SET: cover property (@(posedge ref_clk_in) reg_wr_out);
	COV_SKIP: cover property (@(posedge ref_clk_in)
		cycle_end && !flush_r && (is_skip_clr || is_skip_set) ##1 flush_r);
	COV_INDEXED: cover property (@(posedge ref_clk_in)
		reg_rd_out && !bank_bit && ext_set_en_in
		&& f_addr <= bbd_pkg::IDX_LIMIT);
endmodule

/* File: bbd_pkg.sv */
// package of constants for the branch and bit operation decode slice
// assumes one core clock; a q-phase counter divides each cycle in four
//
// Summary of operation
// - top five bits 11010 mark relative branch; low eleven bits signed offset
// - branch target is incremented counter plus twice the signed offset
// - branch takes two cycles: write counter, then one no-operation cycle
// - bit set reads register, forces chosen bit to one, writes back, flags kept
// - bank bit zero picks access bank, one picks bank select register bank
// - extended set, bank bit zero, address up to 95: indexed literal offset
package bbd_pkg;
	localparam int PC_W = 21;
	localparam int ADDR_W = 12;
	localparam logic [4:0] OPC_BRANCH = 5'h1A;
	localparam logic [3:0] OPC_BIT_SET = 4'h8;
	localparam logic [3:0] OPC_SKIP_CLR = 4'hB;
	localparam logic [3:0] OPC_SKIP_SET = 4'hA;
	localparam int OFS_W = 11;
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bbd_phase_e;
endpackage

/* File: bbd_qphase.sv */
// four-phase sequencer of the instruction cycle
// assumes reset_in asynchronous active high on ref_clk_in
`timescale 1ns/1ns
module bbd_qphase (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	output bbd_pkg::bbd_phase_e phase_out,
	output logic cycle_end_out
);
	bbd_pkg::bbd_phase_e phase_r;
	bbd_pkg::bbd_phase_e phase_nxt;

	// step through q1..q4 and wrap
	always_comb begin
		unique case (phase_r)
			bbd_pkg::Q1: phase_nxt = bbd_pkg::Q2;
			bbd_pkg::Q2: phase_nxt = bbd_pkg::Q3;
			bbd_pkg::Q3: phase_nxt = bbd_pkg::Q4;
			bbd_pkg::Q4: phase_nxt = bbd_pkg::Q1;
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_r <= bbd_pkg::Q1;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign phase_out = phase_r;
	assign cycle_end_out = (phase_r == bbd_pkg::Q4);
endmodule

/* File: branch_and_bit_op_decode_test.sv */
// testbench of the branch and bit operation decode slice
// assumes bbd_decode as top, one instruction per four clocks
`timescale 1ns/1ns
module branch_and_bit_op_decode_test;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [15:0] instr_in = 16'h0000;
	logic [3:0] bank_in = 4'h0;
	logic ext_in = 1'b0;
	logic [11:0] base_in = 12'h000;
	logic [7:0] rdata_in = 8'h00;
	logic [20:0] pc_out;
	logic [11:0] addr_out;
	logic rd_out, wr_out, st_out, flush_out;
	logic [7:0] wdata_out;
	logic [1:0] phase_out;
	int num_errors = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h05A71246;
	logic [20:0] m_pc = 21'h000002;
	logic m_flush = 1'b0;
	// ==========================================================
	// design and clock
	bbd_decode DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.instr_in(instr_in), .bank_select_register_in(bank_in),
		.ext_set_en_in(ext_in), .index_base_in(base_in),
		.reg_rdata_in(rdata_in), .pc_out(pc_out), .reg_addr_out(addr_out),
		.reg_rd_out(rd_out), .reg_wr_out(wr_out), .reg_wdata_out(wdata_out),
		.status_wr_out(st_out), .flush_out(flush_out),
		.phase_out(phase_out));
	// 125 MHz clock
	always #4 ref_clk_in = ~ref_clk_in;
	// ==========================================================
	// helpers
	function logic [31:0] nxt_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk_pc(input logic [20:0] got, input logic [20:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t pc got %h want %h", $time, got, exp);
		end
	endtask
	task chk_reg(input logic [11:0] got, input logic [11:0] exp,
			input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// one instruction cycle, started at its first rising edge
	task automatic run(input logic [15:0] ins);
		logic [31:0] r;
		logic [7:0] rd, f;
		logic [11:0] ea;
		logic br, bs, sk, cond, bop;
		logic [7:0] wd;
		logic [20:0] ofs;
		r = nxt_rand();
		rd = r[7:0];
		f = ins[7:0];
		instr_in <= ins;
		rdata_in <= rd;
		bank_in <= r[11:8];
		ext_in <= r[12];
		base_in <= r[27:16];
		if (ins[8]) ea = {r[11:8], f};
		else if (r[12] && f <= 8'h5F) ea = r[27:16] + {4'h0, f};
		else if (f < 8'h60) ea = {4'h0, f};
		else ea = {4'hF, f};
		br = (ins[15:11] == bbd_pkg::OPC_BRANCH);
		bs = (ins[15:12] == bbd_pkg::OPC_BIT_SET);
		sk = (ins[15:12] == bbd_pkg::OPC_SKIP_CLR) ||
			(ins[15:12] == bbd_pkg::OPC_SKIP_SET);
		cond = (ins[15:12] == bbd_pkg::OPC_SKIP_CLR) ? !rd[ins[11:9]]
			: rd[ins[11:9]];
		bop = (bs || sk) && !m_flush;
		wd = rd | (8'h01 << ins[11:9]);
		ofs = {{9{ins[10]}}, ins[10:0], 1'b0};
		for (int q = 0; q < 4; q++) begin
			@(negedge ref_clk_in);
			chk_reg(12'(phase_out), 12'(q), "phase");
			if (q == 2) chk_pc(pc_out, m_pc);
			if (q == 2) chk_reg(12'(flush_out), 12'(m_flush), "flush");
			chk_reg(12'(wr_out), 12'(q == 3 && bs && !m_flush), "wr");
			chk_reg(12'(st_out), 12'h000, "status");
			chk_reg(12'(rd_out), 12'(q == 1 && bop), "rd");
			if (q == 1 && bop)
				chk_reg(addr_out, ea, "addr");
			if (q == 3 && bs && !m_flush)
				chk_reg(12'(wdata_out), 12'(wd), "wdata");
			@(posedge ref_clk_in);
		end
		// next counter and nop marking
		if (br && !m_flush) m_pc = m_pc + ofs;
		else m_pc = m_pc + 21'h000002;
		m_flush = !m_flush && (br || (sk && cond));
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// main sequence: boundary branches, a bit set placed in the nop cycle after a branch, two skips, then random mix of the opcodes
	initial begin
		logic [31:0] r;
		repeat (6) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		run(16'hD400); run(16'hD3FF); run(16'h0000); run(16'hD3FF);
		run(16'h8E05); run(16'hB05F); run(16'hA160); run(16'h0000);
		$display("directed test done");
		for (int i = 0; i < 300; i++) begin
			r = nxt_rand();
			case (r[31:30])
				2'h0: run({bbd_pkg::OPC_BRANCH, r[10:0]});
				2'h1: run({bbd_pkg::OPC_BIT_SET, r[11:0]});
				2'h2: run({bbd_pkg::OPC_SKIP_CLR, r[11:0]});
				default: run({bbd_pkg::OPC_SKIP_SET, r[11:0]});
			endcase
		end
		$display("random test done");
		wrap_up();
	end
	// watchdog well past the expected 1238 clocks
	initial begin
		#(8 * 20000);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
